// file: core/vtm_pkg.sv
// constants and carrier types for the voltage and temperature monitor
package vtm_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_GAIN = 6'h15;
    localparam logic [5:0] IDX_CTRL_A = 6'h17;
    localparam logic [5:0] IDX_CTRL_B = 6'h18;
    localparam logic [5:0] IDX_V0_LIM = 6'h19;
    localparam logic [5:0] IDX_V1_LIM = 6'h1A;
    localparam logic [5:0] IDX_T_LIM = 6'h1B;
    localparam logic [5:0] IDX_ALARM_EN = 6'h1D;
    localparam logic [5:0] IDX_STATUS = 6'h26;
    localparam logic [5:0] IDX_MASK = 6'h27;
    localparam logic [5:0] IDX_V0_PEAK = 6'h28;
    localparam logic [5:0] IDX_V0_FLOOR = 6'h29;
    localparam logic [5:0] IDX_V1_PEAK = 6'h2A;
    localparam logic [5:0] IDX_V1_FLOOR = 6'h2B;

    // values after reset
    localparam logic [7:0] RST_GAIN = 8'h20;
    localparam logic [7:0] RST_CTRL_A = 8'h3C;
    localparam logic [7:0] RST_CTRL_B = 8'h80;
    localparam logic [7:0] RST_LIMITS = 8'h62;
    localparam logic [7:0] RST_ALARM_EN = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [5:0] RST_STATUS = 6'h00;
    localparam logic [7:0] RST_PEAK = 8'h00;
    localparam logic [7:0] RST_FLOOR = 8'hFF;

    // field positions
    localparam int unsigned GAIN_CODE_MSB = 6;
    localparam int unsigned MON_EN_MSB = 3;
    localparam int unsigned MON_EN_LSB = 2;
    localparam int unsigned SEL_PIN_ZERO = 0;
    localparam int unsigned SEL_PIN_ONE = 1;
    localparam int unsigned GAIN_APPLY_BIT = 7;
    localparam int unsigned LIM_UPPER_MSB = 6;
    localparam int unsigned LIM_UPPER_LSB = 4;
    localparam int unsigned LIM_LOWER_MSB = 2;
    localparam int unsigned LIM_LOWER_LSB = 0;
    localparam int unsigned QUANT_LSB = 5;
    localparam int unsigned NUM_FLAGS = 6;

    // monitor enable codes
    localparam logic [1:0] MON_ON = 2'h3;

    // channels; flag 2*ch is under, 2*ch+1 is over
    localparam int unsigned CH_V0 = 0;
    localparam int unsigned CH_V1 = 1;
    localparam int unsigned CH_T = 2;
    localparam int unsigned NUM_CH = 3;

    // one conversion result from the converter, all channels at once
    typedef struct packed {
        logic valid;
        logic [7:0] temp;
        logic [7:0] voltOne;
        logic [7:0] voltZero;
    } vtm_sample_s;

    // one channel's pair of 3-bit limits
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } vtm_limits_s;

endpackage

// file: core/vtm_monitor.sv
// configuration, limit comparison and alarm logic of the voltage and temperature monitor
`timescale 1ns/10ps
`default_nettype none

module vtm_monitor
    import vtm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // converter side
    input wire vtm_sample_s sample,
    output logic [1:0] sensorEnable,
    output logic [1:0] pinSenseSel,
    // interrupt
    output logic irq
);

    logic [7:0] gain_q;
    logic [7:0] ctrlA_q;
    logic [7:0] ctrlB_q;
    logic [7:0] limits_q [NUM_CH];
    logic [7:0] alarmEn_q;
    logic [7:0] mask_q;
    logic [NUM_FLAGS-1:0] status_q;
    logic [NUM_FLAGS-1:0] status_d;
    logic [NUM_FLAGS-1:0] statusEvt;
    logic waitReq_q;
    logic [31:0] rdData_q;
    logic irq_q;
    logic [5:0] regIdx;
    logic wrAccept;
    logic [7:0] wrByte;
    logic [7:0] rdMux;
    logic monOn;
    logic gainApply;
    logic [NUM_CH-1:0] chActive;
    logic [7:0] rawReading [NUM_CH];
    logic [7:0] peakRd [2];
    logic [7:0] floorRd [2];

    // scale a raw pin reading by 128/code; saturates rather than wraps
    function automatic logic [7:0] applyGain(input logic [7:0] raw, input logic [6:0] code,
                                             input logic apply);
        logic [14:0] quo;
        logic [7:0] res;
        quo = 15'h0000;
        res = raw;
        if (apply && code != 7'h00) begin
            quo = {raw, 7'h00} / {8'h00, code};
        end
        if (apply) begin
            if (code == 7'h00 || quo > 15'h00FF) begin
                res = 8'hFF;
            end else begin
                res = quo[7:0];
            end
        end
        return res;
    endfunction

    assign regIdx = avs_address[7:2];
    // a write lands on the edge where waitrequest is seen low; only byte lane 0 carries data
    assign wrAccept = avs_write && !waitReq_q && avs_byteenable[0];
    assign wrByte = avs_writedata[7:0];

    assign monOn = (ctrlA_q[MON_EN_MSB:MON_EN_LSB] == MON_ON);
    assign gainApply = ctrlB_q[GAIN_APPLY_BIT];

    // a channel is compared only while monitors are on and, for pins, selected
    assign chActive[CH_V0] = monOn && ctrlA_q[SEL_PIN_ZERO];
    assign chActive[CH_V1] = monOn && ctrlA_q[SEL_PIN_ONE];
    assign chActive[CH_T] = monOn;

    assign rawReading[CH_V0] = sample.voltZero;
    assign rawReading[CH_V1] = sample.voltOne;
    assign rawReading[CH_T] = sample.temp;

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [7:0] scaled;
            logic [2:0] level;
            vtm_limits_s lim;

            if (ch == CH_T) begin : g_temp
                assign scaled = rawReading[ch];
            end else begin : g_volt
                assign scaled = applyGain(rawReading[ch], gain_q[GAIN_CODE_MSB:0], gainApply);
            end

            assign lim.upper = limits_q[ch][LIM_UPPER_MSB:LIM_UPPER_LSB];
            assign lim.lower = limits_q[ch][LIM_LOWER_MSB:LIM_LOWER_LSB];
            // same 3-bit scale as the limit fields
            assign level = scaled[7:QUANT_LSB];

            // strict compare: a level equal to a limit raises nothing
            assign statusEvt[2*ch+1] = sample.valid && chActive[ch] && alarmEn_q[2*ch+1]
                                       && (level > lim.upper);
            assign statusEvt[2*ch] = sample.valid && chActive[ch] && alarmEn_q[2*ch]
                                     && (level < lim.lower);

            if (ch != CH_T) begin : g_track
                logic [7:0] peak_q;
                logic [7:0] floor_q;

                // extremes follow the gained reading, not the 3-bit level
                always_ff @(posedge mclk) begin
                    if (!rst_n) begin
                        peak_q <= RST_PEAK;
                        floor_q <= RST_FLOOR;
                    end else if (sample.valid && chActive[ch]) begin
                        if (scaled > peak_q) begin
                            peak_q <= scaled;
                        end
                        if (scaled < floor_q) begin
                            floor_q <= scaled;
                        end
                    end
                end

                assign peakRd[ch] = peak_q;
                assign floorRd[ch] = floor_q;
            end
        end
    endgenerate

    // configuration registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gain_q <= RST_GAIN;
            ctrlA_q <= RST_CTRL_A;
            ctrlB_q <= RST_CTRL_B;
        end else if (wrAccept) begin
            if (regIdx == IDX_GAIN) begin
                gain_q <= wrByte;
            end
            if (regIdx == IDX_CTRL_A) begin
                ctrlA_q <= wrByte;
            end
            if (regIdx == IDX_CTRL_B) begin
                ctrlB_q <= wrByte;
            end
        end
    end

    // limit registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            limits_q[CH_V0] <= RST_LIMITS;
            limits_q[CH_V1] <= RST_LIMITS;
            limits_q[CH_T] <= RST_LIMITS;
        end else if (wrAccept) begin
            if (regIdx == IDX_V0_LIM) begin
                limits_q[CH_V0] <= wrByte;
            end
            if (regIdx == IDX_V1_LIM) begin
                limits_q[CH_V1] <= wrByte;
            end
            if (regIdx == IDX_T_LIM) begin
                limits_q[CH_T] <= wrByte;
            end
        end
    end

    // alarm enables and interrupt mask
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarmEn_q <= RST_ALARM_EN;
            mask_q <= RST_MASK;
        end else if (wrAccept) begin
            if (regIdx == IDX_ALARM_EN) begin
                alarmEn_q <= wrByte;
            end
            if (regIdx == IDX_MASK) begin
                mask_q <= wrByte;
            end
        end
    end

    // sticky flags; a new event beats a write-one-to-clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (wrAccept && regIdx == IDX_STATUS) begin
            status_d = status_d & ~wrByte[NUM_FLAGS-1:0];
        end
        status_d = status_d | statusEvt;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q <= RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    // registered level; follows the flags one cycle late
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q[NUM_FLAGS-1:0]);
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        unique case (regIdx)
            IDX_GAIN: rdMux = gain_q;
            IDX_CTRL_A: rdMux = ctrlA_q;
            IDX_CTRL_B: rdMux = ctrlB_q;
            IDX_V0_LIM: rdMux = limits_q[CH_V0];
            IDX_V1_LIM: rdMux = limits_q[CH_V1];
            IDX_T_LIM: rdMux = limits_q[CH_T];
            IDX_ALARM_EN: rdMux = alarmEn_q;
            IDX_STATUS: rdMux = {2'b00, status_q};
            IDX_MASK: rdMux = mask_q;
            IDX_V0_PEAK: rdMux = peakRd[CH_V0];
            IDX_V0_FLOOR: rdMux = floorRd[CH_V0];
            IDX_V1_PEAK: rdMux = peakRd[CH_V1];
            IDX_V1_FLOOR: rdMux = floorRd[CH_V1];
            default: rdMux = 8'h00;
        endcase
    end

    // fixed two-cycle answer: data is captured one edge before it is taken,
    // so the master's held request keeps the mux stable in between
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            waitReq_q <= 1'b1;
            rdData_q <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && waitReq_q) begin
            waitReq_q <= 1'b0;
            rdData_q <= avs_read ? {24'h00_0000, rdMux} : 32'h0000_0000;
        end else begin
            waitReq_q <= 1'b1;
        end
    end

    assign avs_readdata = rdData_q;
    assign avs_waitrequest = waitReq_q;
    assign sensorEnable = ctrlA_q[MON_EN_MSB:MON_EN_LSB];
    assign pinSenseSel = ctrlA_q[SEL_PIN_ONE:SEL_PIN_ZERO];
    assign irq = irq_q;

endmodule

`default_nettype wire

// file: bench/vtm_monitor_asserts.sv
// assertion checker for the monitor's bus, interrupt and control outputs
`timescale 1ns/10ps
`default_nettype none
module vtm_monitor_asserts
    import vtm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // converter side and interrupt
    input wire vtm_sample_s sample,
    input wire logic [1:0] sensorEnable,
    input wire logic [1:0] pinSenseSel,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic wrDone;
    assign wrDone = avs_write && !avs_waitrequest && avs_byteenable[0];
    sequence seqTaken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence seqAnswer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (seqTaken |=> seqAnswer)
        else $error("bus answer not a single cycle after request");
    AST_BUS_IDLE: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("bus answered without request");
    AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && avs_address[7:2] == 6'h00 |=>
        avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_READ_UPPER: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_CTRL_WRITE: assert property (wrDone && avs_address[7:2] == IDX_CTRL_A |=>
        {sensorEnable, pinSenseSel} == $past(avs_writedata[3:0])) else $error("control field not written");
    AST_CTRL_HOLD: assert property (!$stable({sensorEnable, pinSenseSel}) |->
        $past(wrDone && avs_address[7:2] == IDX_CTRL_A)) else $error("control field changed alone");
    // irq lags status by a cycle, so its cause sits two edges back
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(sample.valid, 2) || $past(wrDone, 2))
        else $error("interrupt rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wrDone, 2))
        else $error("interrupt fell without write");
endmodule
bind vtm_monitor vtm_monitor_asserts vtm_monitor_asserts_i (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample(sample), .sensorEnable(sensorEnable), .pinSenseSel(pinSenseSel), .irq(irq));
`default_nettype wire

// file: bench/tb_top.sv
// self-checking testbench for the voltage and temperature monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top import vtm_pkg::*;;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    vtm_sample_s sample = '0;
    logic [1:0] sensorEnable;
    logic [1:0] pinSenseSel;
    logic irq;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h8;
    logic [31:0] r;
    logic [31:0] rdq;
    logic [7:0] mdl [64];
    logic [7:0] gains [5] = '{8'h40, 8'h10, 8'h01, 8'h00, 8'h7F};
    always #12.5 mclk = ~mclk;
    vtm_monitor vtm_monitor_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample(sample),
        .sensorEnable(sensorEnable), .pinSenseSel(pinSenseSel), .irq(irq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one bus transfer; the model follows only writes that really land
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {4{d}};
        avs_byteenable <= be;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n == 20) chk(32'h1, 32'h0);
        rdq = avs_readdata;
        if (w && be[0]) begin
            case (idx)
                IDX_STATUS: mdl[idx] &= ~d;
                IDX_GAIN, IDX_CTRL_A, IDX_CTRL_B, IDX_V0_LIM, IDX_V1_LIM, IDX_T_LIM, IDX_ALARM_EN, IDX_MASK: mdl[idx] = d;
                default: ;
            endcase
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [5:0] idx);
        xfer(1'b0, idx, 8'h00, 4'h0);
        chk(rdq, {24'h0, mdl[idx]});
    endtask
    function automatic logic [7:0] scl(input logic [7:0] raw);
        int x;
        if (!mdl[IDX_CTRL_B][GAIN_APPLY_BIT]) return raw;
        if (mdl[IDX_GAIN][6:0] == 7'h00) return 8'hFF;
        x = raw * 128 / mdl[IDX_GAIN][6:0];
        return (x > 255) ? 8'hFF : 8'(x);
    endfunction
    // one conversion, then status, interrupt, fields and extremes compared
    task automatic step(input logic [7:0] v0, input logic [7:0] v1, input logic [7:0] t, input logic [7:0] clr);
        logic [7:0] v;
        logic [7:0] lim;
        logic [5:0] pk;
        sample <= {1'b1, t, v1, v0};
        @(posedge mclk);
        sample.valid <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            if (mdl[IDX_CTRL_A][3:2] == MON_ON && (c == 2 || mdl[IDX_CTRL_A][c])) begin
                v = (c == 2) ? t : scl(c == 1 ? v1 : v0);
                lim = mdl[IDX_V0_LIM + 6'(c)];
                pk = IDX_V0_PEAK + 6'(2 * c);
                if (c < 2 && v > mdl[pk]) mdl[pk] = v;
                if (c < 2 && v < mdl[pk + 1]) mdl[pk + 1] = v;
                mdl[IDX_STATUS] |= mdl[IDX_ALARM_EN] & (8'({v[7:5] > lim[6:4], v[7:5] < lim[2:0]}) << (2 * c));
            end
        end
        @(posedge mclk);
        rd(IDX_STATUS);
        chk({31'h0, irq}, {31'h0, |(mdl[IDX_STATUS] & mdl[IDX_MASK])});
        chk({28'h0, sensorEnable, pinSenseSel}, {28'h0, mdl[IDX_CTRL_A][3:0]});
        for (int k = 0; k < 4; k++) begin
            rd(IDX_V0_PEAK + 6'(k));
        end
        xfer(1'b1, IDX_STATUS, clr, 4'h1);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        mdl = '{default: 8'h00};
        mdl[IDX_GAIN] = RST_GAIN;
        mdl[IDX_CTRL_A] = RST_CTRL_A;
        mdl[IDX_CTRL_B] = RST_CTRL_B;
        mdl[IDX_V0_LIM] = RST_LIMITS;
        mdl[IDX_V1_LIM] = RST_LIMITS;
        mdl[IDX_T_LIM] = RST_LIMITS;
        mdl[IDX_V0_FLOOR] = RST_FLOOR;
        mdl[IDX_V1_FLOOR] = RST_FLOOR;
        @(posedge mclk);
        chk({28'h0, sensorEnable, pinSenseSel}, {28'h0, MON_ON, 2'b00});
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 64; i++) begin
            rd(6'(i));
        end
    endtask
    initial begin
        @(posedge mclk);
        do_reset();
        $display("test reset done");
        xfer(1'b1, IDX_ALARM_EN, 8'h3F, 4'h1);
        xfer(1'b1, IDX_MASK, 8'h3F, 4'h1);
        xfer(1'b1, IDX_GAIN, 8'h55, 4'hE);
        rd(IDX_GAIN);
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, IDX_CTRL_A, 8'(i), 4'h1);
            step(8'h05, 8'h3A, 8'hE0, 8'hFF);
        end
        $display("test select and enable done");
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, IDX_GAIN, gains[i], 4'h1);
            step(8'h21, 8'h48, 8'h40, 8'hFF);
        end
        xfer(1'b1, IDX_CTRL_B, 8'h00, 4'h1);
        step(8'h21, 8'h48, 8'h40, 8'hFF);
        $display("test gain done");
        // a new event and a write-one-to-clear land on the same edge: the set must win
        fork
            xfer(1'b1, IDX_STATUS, 8'hFF, 4'h1);
            begin
                @(posedge mclk);
                sample <= {1'b1, 8'hE0, 8'h48, 8'h48};
                @(posedge mclk);
                sample.valid <= 1'b0;
            end
        join
        mdl[IDX_STATUS] = 8'h20;
        rd(IDX_STATUS);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, IDX_STATUS, 8'hFF, 4'h1);
        $display("test set over clear done");
        repeat (300) begin
            r = rnd();
            xfer(1'b1, r[5] ? 6'h15 + 6'(r[4:0] % 23) : r[11:6], r[19:12], {r[27:25], |r[22:20]});
            r = rnd();
            step(r[7:0], r[15:8], r[23:16], 8'(rnd()));
            r = rnd();
            rd(r[5:0]);
        end
        $display("test random done");
        do_reset();
        $display("test second reset done");
        wrap_up();
    end
    // a run needs about 9000 cycles; twice that means a hang
    initial begin
        #(25 * 20000);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
